// ===== design/pslq_bcd_convert.sv
// sequential binary to decimal digit converter for the query answers
`timescale 1ns/100ps
module pslq_bcd_convert (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // request
   input wire logic i_start,
   input wire logic [pslq_pkg::INPUT_WORD_W-1:0] i_value,
   // result
   output logic o_busy,
   output logic o_done,
   output logic [pslq_pkg::BCD_W-1:0] o_bcd
);
   import pslq_pkg::*;

   logic [INPUT_WORD_W-1:0] shift;
   logic [INPUT_WORD_W-1:0] next_shift;
   logic [BCD_W-1:0] next_bcd;
   logic [BCD_W-1:0] adjusted;
   logic [4:0] step;
   logic [4:0] next_step;
   logic next_busy;
   logic next_done;

   // one bit per cycle: slow, but a query answer is not time critical
   always_comb begin
      adjusted = o_bcd;
      for (int d = 0; d < BCD_DIGITS; d++) begin
         if (o_bcd[4*d +: 4] > 4'h4) begin
            adjusted[4*d +: 4] = o_bcd[4*d +: 4] + 4'h3;
         end
      end
      next_shift = shift;
      next_bcd = o_bcd;
      next_step = step;
      next_busy = o_busy;
      next_done = 1'b0;
      if (o_busy) begin
         next_bcd = {adjusted[BCD_W-2:0], shift[INPUT_WORD_W-1]};
         next_shift = {shift[INPUT_WORD_W-2:0], 1'b0};
         next_step = step - 5'h01;
         if (step == 5'h01) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end else if (i_start) begin
         next_shift = i_value;
         next_bcd = '0;
         next_step = CONV_STEPS;
         next_busy = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         shift <= '0;
         o_bcd <= '0;
         step <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         shift <= next_shift;
         o_bcd <= next_bcd;
         step <= next_step;
         o_busy <= next_busy;
         o_done <= next_done;
      end
   end

   // checking aids
   logic [INPUT_WORD_W-1:0] value_hold;
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         value_hold <= '0;
      end else if (i_start && !o_busy) begin
         value_hold <= i_value;
      end
   end

   function automatic logic [INPUT_WORD_W-1:0] bcd_value(input logic [BCD_W-1:0] b);
      int acc;
      acc = 0;
      for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
         acc = acc * 10 + int'(b[4*d +: 4]);
      end
      return acc[INPUT_WORD_W-1:0];
   endfunction : bcd_value

   property p_conv_value;
      @(posedge i_clock) disable iff (i_reset)
      o_done |-> (bcd_value(o_bcd) == value_hold);
   endproperty
   a_conv_value: assert property (p_conv_value) else $error("decimal result wrong");

   property p_conv_time;
      @(posedge i_clock) disable iff (i_reset)
      (i_start && !o_busy) |=> o_busy [*8] ##17 o_done;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");
endmodule : pslq_bcd_convert

// ===== design/pslq_pkg.sv
// constants and types of the process status and log query block
// Functional notes
// - input-state query answers 24-bit word in decimal
// - input bit reads 1 high, 0 low
// - unassigned input-word bits always read zero
// - bits 16-23 carry process inputs one-eight
// - head control inputs sit at fixed bits
// - every process event appends a log entry
// - first query gives newest, next steps older
// - host repeats next; device ends with ampersand
// - readout shows log as at first query; here a write past the free slots drops the oldest unread entry
// - state/mode entry: stamp, bitfields, channel, value
// - general entry: stamp then event description
// - clear command discards every log entry
// - relay query answers 8-bit word in decimal
// - relay bit 1 means relay untrustworthy
package pslq_pkg;
   localparam int INPUT_WORD_W = 24;
   localparam int BIT_DEGAS = 2;
   localparam int BIT_FIL_LOCK = 3;
   localparam int BIT_KEY_INH = 4;
   localparam int BIT_ERASE_REQ = 7;
   localparam int BIT_REMOTE = 8;
   localparam int BIT_FIL_REQ = 9;
   localparam int BIT_TRIG_INH = 11;
   localparam int BIT_PROC_BASE = 16;
   localparam int HEAD_INPUTS = 7;
   localparam int PROC_INPUTS = 8;
   localparam int RELAY_W = 8;
   localparam int RAW_W = HEAD_INPUTS + PROC_INPUTS + RELAY_W;
   localparam logic [23:0] UNUSED_MASK = 24'h00F463;
   localparam int BCD_DIGITS = 8;
   localparam int BCD_W = 32;
   localparam logic [4:0] CONV_STEPS = 5'h18;
   localparam int LOG_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] LOG_FULL = 5'h10;
   localparam int STAMP_W = 32;
   localparam int CODE_W = 8;
   localparam int CHAN_W = 3;
   localparam logic [7:0] END_MARKER = 8'h26;
   localparam logic [1:0] SETTLE_DONE = 2'h3;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_INPUT_STATE = 3'h1,
      CMD_LOG_FIRST = 3'h2,
      CMD_LOG_NEXT = 3'h3,
      CMD_LOG_CLEAR = 3'h4,
      CMD_RELAY_FAULT = 3'h5
   } pslq_cmd_e;

   typedef enum logic [1:0] {
      RESP_WORD = 2'h0,
      RESP_ENTRY = 2'h1,
      RESP_END = 2'h2
   } pslq_resp_e;

   typedef enum logic [1:0] {
      ENTRY_STATE = 2'h0,
      ENTRY_MODE = 2'h1,
      ENTRY_EVENT = 2'h2
   } pslq_entry_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONVERT = 2'h1,
      ST_ANSWER = 2'h3
   } pslq_state_e;

   typedef struct packed {
      pslq_entry_e kind;
      logic [STAMP_W-1:0] stamp;
      logic [7:0] state_bits;
      logic [7:0] mode_bits;
      logic [CHAN_W-1:0] channel;
      logic value;
      logic [CODE_W-1:0] code;
   } pslq_entry_s;
endpackage : pslq_pkg

// ===== design/pslq_process_status_log_query.sv
// input-state and relay fault queries with a snapshot-read process event log
`timescale 1ns/100ps
module pslq_process_status_log_query (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // analyzer-head control pins
   input wire logic i_head_degas_active,
   input wire logic i_filament_lockout,
   input wire logic i_keypad_inhibit,
   input wire logic i_history_erase_request,
   input wire logic i_remote_control_allow,
   input wire logic i_filament_request,
   input wire logic i_scan_trigger_inhibit,
   // process control pins and relay monitor
   input wire logic [pslq_pkg::PROC_INPUTS-1:0] i_process_inputs,
   input wire logic [pslq_pkg::RELAY_W-1:0] i_relay_fault,
   // command from the host interpreter
   input wire logic i_cmd_valid,
   input wire pslq_pkg::pslq_cmd_e i_cmd,
   output logic o_cmd_ready,
   // process events to log
   input wire logic i_event_valid,
   input wire pslq_pkg::pslq_entry_e i_event_kind,
   input wire logic [pslq_pkg::STAMP_W-1:0] i_event_stamp,
   input wire logic [7:0] i_event_state_bits,
   input wire logic [7:0] i_event_mode_bits,
   input wire logic [pslq_pkg::CHAN_W-1:0] i_event_channel,
   input wire logic i_event_value,
   input wire logic [pslq_pkg::CODE_W-1:0] i_event_code,
   // answer
   output logic o_resp_valid,
   output pslq_pkg::pslq_resp_e o_resp_kind,
   output logic [pslq_pkg::BCD_W-1:0] o_resp_decimal,
   output logic [7:0] o_resp_char,
   output pslq_pkg::pslq_entry_e o_entry_kind,
   output logic [pslq_pkg::STAMP_W-1:0] o_entry_stamp,
   output logic [7:0] o_entry_state_bits,
   output logic [7:0] o_entry_mode_bits,
   output logic [pslq_pkg::CHAN_W-1:0] o_entry_channel,
   output logic o_entry_value,
   output logic [pslq_pkg::CODE_W-1:0] o_entry_code,
   // status
   output logic [pslq_pkg::CNT_W-1:0] o_log_count,
   output logic o_readout_active
);
   import pslq_pkg::*;

   // pin synchroniser: sync_meta feeds sync_pins only
   logic [RAW_W-1:0] raw_pins;
   logic [RAW_W-1:0] sync_meta;
   logic [RAW_W-1:0] sync_pins;
   assign raw_pins = {i_relay_fault, i_process_inputs, i_scan_trigger_inhibit,
                      i_filament_request, i_remote_control_allow, i_history_erase_request,
                      i_keypad_inhibit, i_filament_lockout, i_head_degas_active};

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         sync_meta <= '0;
         sync_pins <= '0;
      end else begin
         sync_meta <= raw_pins;
         sync_pins <= sync_meta;
      end
   end

   logic [PROC_INPUTS-1:0] proc_level;
   logic [RELAY_W-1:0] relay_level;
   logic [INPUT_WORD_W-1:0] input_word;
   assign proc_level = sync_pins[HEAD_INPUTS +: PROC_INPUTS];
   assign relay_level = sync_pins[HEAD_INPUTS + PROC_INPUTS +: RELAY_W];

   // levels pass straight through, so high reads 1 and low reads 0
   always_comb begin
      input_word = '0;
      input_word[BIT_DEGAS] = sync_pins[0];
      input_word[BIT_FIL_LOCK] = sync_pins[1];
      input_word[BIT_KEY_INH] = sync_pins[2];
      input_word[BIT_ERASE_REQ] = sync_pins[3];
      input_word[BIT_REMOTE] = sync_pins[4];
      input_word[BIT_FIL_REQ] = sync_pins[5];
      input_word[BIT_TRIG_INH] = sync_pins[6];
      input_word[BIT_PROC_BASE +: PROC_INPUTS] = proc_level;
   end

   // event log storage
   pslq_entry_s log_mem [LOG_DEPTH];
   pslq_entry_s event_entry;
   pslq_entry_s newest;
   pslq_entry_s older;
   pslq_entry_s resp_entry;
   pslq_entry_s next_entry;
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] remaining;
   logic [CNT_W-1:0] next_remaining;
   logic [CNT_W-1:0] headroom;
   logic [CNT_W-1:0] next_headroom;
   logic next_active;

   // field order of an entry is stamp, bitfields, channel, value or description
   assign event_entry = '{kind: i_event_kind, stamp: i_event_stamp,
                          state_bits: i_event_state_bits, mode_bits: i_event_mode_bits,
                          channel: i_event_channel, value: i_event_value,
                          code: i_event_code};
   assign newest = log_mem[wr_ptr - PTR_ONE];
   assign older = log_mem[rd_ptr];

   always_ff @(posedge i_clock) begin
      if (i_event_valid) begin
         log_mem[wr_ptr] <= event_entry;
      end
   end

   // command sequencing
   pslq_state_e state;
   pslq_state_e next_state;
   logic take;
   logic clear_cmd;
   logic conv_start;
   logic conv_done;
   logic [INPUT_WORD_W-1:0] conv_value;
   logic [BCD_W-1:0] conv_bcd;
   logic next_resp_valid;
   pslq_resp_e next_resp_kind;
   logic [BCD_W-1:0] next_resp_decimal;
   logic [7:0] next_resp_char;

   assign o_cmd_ready = (state == ST_IDLE);
   assign take = i_cmd_valid && o_cmd_ready;
   assign clear_cmd = take && (i_cmd == CMD_LOG_CLEAR);
   assign conv_start = take && ((i_cmd == CMD_INPUT_STATE) || (i_cmd == CMD_RELAY_FAULT));
   assign conv_value = (i_cmd == CMD_RELAY_FAULT) ?
                       {{(INPUT_WORD_W - RELAY_W){1'b0}}, relay_level} : input_word;

   pslq_bcd_convert u_convert (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_start(conv_start),
      .i_value(conv_value),
      .o_busy(),
      .o_done(conv_done),
      .o_bcd(conv_bcd)
   );

   always_comb begin
      next_state = state;
      next_wr_ptr = wr_ptr;
      next_count = o_log_count;
      next_rd_ptr = rd_ptr;
      next_remaining = remaining;
      next_headroom = headroom;
      next_active = o_readout_active;
      next_resp_valid = 1'b0;
      next_resp_kind = o_resp_kind;
      next_resp_decimal = o_resp_decimal;
      next_resp_char = o_resp_char;
      next_entry = resp_entry;
      case (state)
         ST_IDLE: begin
            if (take) begin
               case (i_cmd)
                  CMD_INPUT_STATE, CMD_RELAY_FAULT: begin
                     next_state = ST_CONVERT;
                  end
                  CMD_LOG_FIRST: begin
                     next_state = ST_ANSWER;
                     next_resp_valid = 1'b1;
                     if (o_log_count != '0) begin
                        next_resp_kind = RESP_ENTRY;
                        next_entry = newest;
                        next_rd_ptr = wr_ptr - PTR_ONE - PTR_ONE;
                        next_remaining = o_log_count - CNT_ONE;
                        next_headroom = LOG_FULL - o_log_count;
                        next_active = 1'b1;
                     end else begin
                        next_resp_kind = RESP_END;
                        next_resp_char = END_MARKER;
                        next_remaining = '0;
                        next_active = 1'b0;
                     end
                  end
                  CMD_LOG_NEXT: begin
                     next_state = ST_ANSWER;
                     next_resp_valid = 1'b1;
                     if (o_readout_active && (remaining != '0)) begin
                        next_resp_kind = RESP_ENTRY;
                        next_entry = older;
                        next_rd_ptr = rd_ptr - PTR_ONE;
                        next_remaining = remaining - CNT_ONE;
                     end else begin
                        next_resp_kind = RESP_END;
                        next_resp_char = END_MARKER;
                        next_active = 1'b0;
                     end
                  end
                  CMD_LOG_CLEAR: begin
                     next_count = '0;
                     next_remaining = '0;
                     next_active = 1'b0;
                  end
                  default: begin
                     next_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_CONVERT: begin
            if (conv_done) begin
               next_state = ST_ANSWER;
               next_resp_valid = 1'b1;
               next_resp_kind = RESP_WORD;
               next_resp_decimal = conv_bcd;
            end
         end
         ST_ANSWER: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // an event in the clear cycle survives the clear
      if (i_event_valid) begin
         next_wr_ptr = wr_ptr + PTR_ONE;
         if (next_count != LOG_FULL) begin
            next_count = next_count + CNT_ONE;
         end
         // once the free slots are used, each write eats the oldest unread entry
         if (next_active) begin
            if (next_headroom != '0) begin
               next_headroom = next_headroom - CNT_ONE;
            end else if (next_remaining != '0) begin
               next_remaining = next_remaining - CNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_IDLE;
         wr_ptr <= '0;
         o_log_count <= '0;
         rd_ptr <= '0;
         remaining <= '0;
         headroom <= '0;
         o_readout_active <= 1'b0;
         o_resp_valid <= 1'b0;
         o_resp_kind <= RESP_WORD;
         o_resp_decimal <= '0;
         o_resp_char <= '0;
         resp_entry <= '0;
      end else begin
         state <= next_state;
         wr_ptr <= next_wr_ptr;
         o_log_count <= next_count;
         rd_ptr <= next_rd_ptr;
         remaining <= next_remaining;
         headroom <= next_headroom;
         o_readout_active <= next_active;
         o_resp_valid <= next_resp_valid;
         o_resp_kind <= next_resp_kind;
         o_resp_decimal <= next_resp_decimal;
         o_resp_char <= next_resp_char;
         resp_entry <= next_entry;
      end
   end

   assign o_entry_kind = resp_entry.kind;
   assign o_entry_stamp = resp_entry.stamp;
   assign o_entry_state_bits = resp_entry.state_bits;
   assign o_entry_mode_bits = resp_entry.mode_bits;
   assign o_entry_channel = resp_entry.channel;
   assign o_entry_value = resp_entry.value;
   assign o_entry_code = resp_entry.code;

   // checking aids
   logic [1:0] settle;
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         settle <= '0;
      end else if (settle != SETTLE_DONE) begin
         settle <= settle + 2'h1;
      end
   end

   sequence s_word_answer;
      o_resp_valid && (o_resp_kind == RESP_WORD);
   endsequence
   sequence s_end_answer;
      o_resp_valid && (o_resp_kind == RESP_END) && (o_resp_char == END_MARKER);
   endsequence

   property p_input_answer;
      @(posedge i_clock) disable iff (i_reset)
      (take && (i_cmd == CMD_INPUT_STATE)) |-> !o_resp_valid [*8] ##19 s_word_answer;
   endproperty
   a_input_answer: assert property (p_input_answer) else $error("input answer late");

   property p_relay_answer;
      @(posedge i_clock) disable iff (i_reset)
      (take && (i_cmd == CMD_RELAY_FAULT)) |-> ##26 s_word_answer;
   endproperty
   a_relay_answer: assert property (p_relay_answer) else $error("relay answer late");

   property p_unused_zero;
      @(posedge i_clock) disable iff (i_reset)
      (input_word & UNUSED_MASK) == '0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

   property p_proc_bits;
      @(posedge i_clock) disable iff (i_reset)
      (settle == SETTLE_DONE) |->
         (input_word[BIT_PROC_BASE +: PROC_INPUTS] == $past(i_process_inputs, 2));
   endproperty
   a_proc_bits: assert property (p_proc_bits) else $error("process bits wrong");

   property p_head_bits;
      @(posedge i_clock) disable iff (i_reset)
      (settle == SETTLE_DONE) |->
         (input_word[BIT_DEGAS] == $past(i_head_degas_active, 2)) &&
         (input_word[BIT_TRIG_INH] == $past(i_scan_trigger_inhibit, 2));
   endproperty
   a_head_bits: assert property (p_head_bits) else $error("head bits wrong");

   property p_first_newest;
      @(posedge i_clock) disable iff (i_reset)
      (take && (i_cmd == CMD_LOG_FIRST) && (o_log_count != '0)) |=>
         o_resp_valid && (o_resp_kind == RESP_ENTRY) && (resp_entry == $past(newest));
   endproperty
   a_first_newest: assert property (p_first_newest) else $error("first not newest");

   property p_idle_next_end;
      @(posedge i_clock) disable iff (i_reset)
      (take && (i_cmd == CMD_LOG_NEXT) && !o_readout_active) |=> s_end_answer;
   endproperty
   a_idle_next_end: assert property (p_idle_next_end) else $error("no end marker");

   property p_clear_empties;
      @(posedge i_clock) disable iff (i_reset)
      (clear_cmd && !i_event_valid) |=> (o_log_count == '0) && !o_readout_active;
   endproperty
   a_clear_empties: assert property (p_clear_empties) else $error("clear left entries");

   property p_event_counted;
      @(posedge i_clock) disable iff (i_reset)
      (i_event_valid && !clear_cmd && (o_log_count != LOG_FULL)) |=>
         (o_log_count == $past(o_log_count) + CNT_ONE);
   endproperty
   a_event_counted: assert property (p_event_counted) else $error("event not logged");

   property p_snapshot_bound;
      @(posedge i_clock) disable iff (i_reset)
      o_readout_active |-> (remaining < o_log_count);
   endproperty
   a_snapshot_bound: assert property (p_snapshot_bound) else $error("readout overrun");
endmodule : pslq_process_status_log_query

// ===== verification/pslq_host_model.sv
// host-side model issuing one text command at a time over the command handshake
`timescale 1ns/100ps
module pslq_host_model (
   // clock and handshake
   input wire logic i_clock,
   input wire logic i_cmd_ready,
   output logic o_cmd_valid,
   output pslq_pkg::pslq_cmd_e o_cmd
);
   import pslq_pkg::*;
   // single host, no web server polling the log, so no one else moves the read position
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd = CMD_NONE;
   end
   // gap lets the host be slow; request holds until the edge that sees ready
   task automatic issue(input pslq_cmd_e c, input int gap);
      repeat (gap) @(posedge i_clock);
      @(posedge i_clock);
      o_cmd_valid <= 1'b1;
      o_cmd <= c;
      do @(negedge i_clock); while (i_cmd_ready !== 1'b1);
      @(posedge i_clock);
      o_cmd_valid <= 1'b0;
   endtask : issue
endmodule : pslq_host_model

// ===== verification/tb_top.sv
// self-checking testbench for the process status and log query block
`timescale 1ns/100ps
module tb_top;
   import pslq_pkg::*;
   logic i_clock, i_reset, cmd_valid, ev_valid, ev_value, o_cmd_ready, o_resp_valid;
   logic o_entry_value, o_readout_active;
   logic [6:0] head;
   logic [7:0] proc_in, relay, ev_sb, ev_mb, ev_code, o_resp_char, o_sb, o_mb, o_code;
   logic [2:0] ev_ch, o_ch;
   logic [31:0] ev_stamp, o_resp_decimal, o_stamp;
   logic [4:0] o_log_count;
   pslq_cmd_e cmd;
   pslq_entry_e ev_kind, o_entry_kind;
   pslq_resp_e o_resp_kind;
   int errors = 0;
   int check_count = 0;

   pslq_host_model host (.i_clock(i_clock), .i_cmd_ready(o_cmd_ready), .o_cmd_valid(cmd_valid),
      .o_cmd(cmd));
   pslq_process_status_log_query uut (.i_clock(i_clock), .i_reset(i_reset),
      .i_head_degas_active(head[0]), .i_filament_lockout(head[1]), .i_keypad_inhibit(head[2]),
      .i_history_erase_request(head[3]), .i_remote_control_allow(head[4]),
      .i_filament_request(head[5]), .i_scan_trigger_inhibit(head[6]),
      .i_process_inputs(proc_in), .i_relay_fault(relay), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
      .o_cmd_ready(o_cmd_ready), .i_event_valid(ev_valid), .i_event_kind(ev_kind),
      .i_event_stamp(ev_stamp), .i_event_state_bits(ev_sb), .i_event_mode_bits(ev_mb),
      .i_event_channel(ev_ch), .i_event_value(ev_value), .i_event_code(ev_code),
      .o_resp_valid(o_resp_valid), .o_resp_kind(o_resp_kind), .o_resp_decimal(o_resp_decimal),
      .o_resp_char(o_resp_char), .o_entry_kind(o_entry_kind), .o_entry_stamp(o_stamp),
      .o_entry_state_bits(o_sb), .o_entry_mode_bits(o_mb), .o_entry_channel(o_ch),
      .o_entry_value(o_entry_value), .o_entry_code(o_code), .o_log_count(o_log_count),
      .o_readout_active(o_readout_active));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   // command then bounded wait for the one-cycle answer pulse
   task automatic ask(input pslq_cmd_e c);
      int n;
      host.issue(c, 0);
      n = 0;
      do begin
         @(negedge i_clock);
         n++;
      end while (o_resp_valid !== 1'b1 && n < 40);
      chk(o_resp_valid, 1'b1);
   endtask : ask

   task automatic log_ev(input pslq_entry_e k, input logic [31:0] st, input logic [2:0] ch,
      input logic [7:0] code);
      @(posedge i_clock);
      ev_valid <= 1'b1;
      ev_kind <= k;
      ev_stamp <= st;
      ev_ch <= ch;
      ev_code <= code;
      ev_sb <= code ^ 8'h5A;
      ev_mb <= code ^ 8'hC3;
      ev_value <= ch[0];
      @(posedge i_clock);
      ev_valid <= 1'b0;
   endtask : log_ev

   task automatic end_marker();
      chk(o_resp_kind, RESP_END);
      chk(o_resp_char, 8'h26);
   endtask : end_marker

   task automatic entry(input logic [31:0] st, input pslq_entry_e k, input logic [2:0] ch,
      input logic [7:0] code);
      chk(o_resp_kind, RESP_ENTRY);
      chk(o_stamp, st);
      chk(o_entry_kind, k);
      chk(o_ch, ch);
      chk(o_code, code);
      chk(o_sb, code ^ 8'h5A);
      chk(o_mb, code ^ 8'hC3);
      chk(o_entry_value, ch[0]);
   endtask : entry

   // word answers are the decimal digits of the packed pin levels
   task automatic t_inputs();
      logic [6:0] hv [3] = '{7'h24, 7'h7F, 7'h4B};
      logic [7:0] pv [3] = '{8'h03, 8'hFF, 8'h80};
      logic [31:0] dv [3] = '{32'h00197136, 32'h16714652, 32'h08390796};
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clock);
         head <= hv[i];
         proc_in <= pv[i];
         repeat (3) @(posedge i_clock);
         ask(CMD_INPUT_STATE);
         chk(o_resp_kind, RESP_WORD);
         chk(o_resp_decimal, dv[i]);
      end
   endtask : t_inputs

   task automatic t_relay();
      @(posedge i_clock);
      relay <= 8'h81;
      repeat (3) @(posedge i_clock);
      ask(CMD_RELAY_FAULT);
      chk(o_resp_decimal, 32'h00000129);
   endtask : t_relay

   task automatic t_log();
      ask(CMD_LOG_FIRST);
      end_marker();
      log_ev(ENTRY_STATE, 32'h11, 3'h0, 8'h01);
      log_ev(ENTRY_MODE, 32'h22, 3'h1, 8'h02);
      log_ev(ENTRY_EVENT, 32'h33, 3'h7, 8'h07);
      @(negedge i_clock);
      chk(o_log_count, 5'h03);
      ask(CMD_LOG_FIRST);
      entry(32'h33, ENTRY_EVENT, 3'h7, 8'h07);
      log_ev(ENTRY_STATE, 32'h44, 3'h2, 8'h04);
      ask(CMD_LOG_NEXT);
      entry(32'h22, ENTRY_MODE, 3'h1, 8'h02);
      ask(CMD_LOG_NEXT);
      entry(32'h11, ENTRY_STATE, 3'h0, 8'h01);
      ask(CMD_LOG_NEXT);
      end_marker();
      chk(o_readout_active, 1'b0);
      ask(CMD_LOG_NEXT);
      end_marker();
   endtask : t_log

   task automatic t_clear();
      host.issue(CMD_LOG_CLEAR, 2);
      @(negedge i_clock);
      chk(o_log_count, 5'h00);
      ask(CMD_LOG_FIRST);
      end_marker();
   endtask : t_clear

   // seventeen events overfill the log; one more during readout eats the oldest unread entry
   task automatic t_full();
      for (int i = 1; i <= 17; i++) begin
         log_ev(ENTRY_EVENT, i, 3'h3, 8'(i));
      end
      @(negedge i_clock);
      chk(o_log_count, 5'h10);
      ask(CMD_LOG_FIRST);
      entry(32'h11, ENTRY_EVENT, 3'h3, 8'h11);
      log_ev(ENTRY_EVENT, 32'h12, 3'h3, 8'h12);
      @(negedge i_clock);
      chk(o_log_count, 5'h10);
      for (int i = 16; i >= 3; i--) begin
         ask(CMD_LOG_NEXT);
         entry(i, ENTRY_EVENT, 3'h3, 8'(i));
      end
      ask(CMD_LOG_NEXT);
      end_marker();
   endtask : t_full

   task automatic end_sim();
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   // a whole run needs about 250 cycles; the limit allows sixteen times that
   initial begin
      #400us;
      errors++;
      end_sim();
   end

   initial begin
      i_reset = 1'b1;
      head = 7'h00;
      proc_in = 8'h00;
      relay = 8'h00;
      ev_valid = 1'b0;
      ev_kind = ENTRY_STATE;
      ev_stamp = 32'h0;
      ev_sb = 8'h00;
      ev_mb = 8'h00;
      ev_ch = 3'h0;
      ev_value = 1'b0;
      ev_code = 8'h00;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      t_inputs();
      t_relay();
      t_log();
      t_clear();
      t_full();
      end_sim();
   end
endmodule : tb_top
